// ### rhd_pkg.sv
// shared constants and types for the root hub descriptor and low-speed threshold registers
package rhd_pkg;
   // ==========================================
   // register offsets
   localparam logic [7:0] RHD_OFS_LS_THRESH = 8'h44;
   localparam logic [7:0] RHD_OFS_DESC_A = 8'h48;

   // ==========================================
   // field positions
   localparam int RHD_LST_MSB = 11;
   localparam int RHD_PGW_LSB = 24;
   localparam int RHD_NO_OVERCURRENT_PROTECTION_BIT = 12;
   localparam int RHD_OVERCURRENT_REPORT_MODE_BIT = 11;
   localparam int RHD_DT_BIT = 10;
   localparam int RHD_NPS_BIT = 9;
   localparam int RHD_PSM_BIT = 8;
   localparam int RHD_FR_W = 14;

   // ==========================================
   // reset values
   localparam logic [31:0] RHD_LS_THRESH_RST = 32'h0000_0628;
   localparam logic [7:0] RHD_PGW_RST = 8'hFF;
   localparam logic RHD_NO_OVERCURRENT_PROTECTION_RST = 1'b0;
   localparam logic RHD_NPS_RST = 1'b0;
   localparam logic RHD_PSM_RST = 1'b1;
   localparam logic [7:0] RHD_NDP_ONE_PORT = 8'h01;
   localparam logic [7:0] RHD_NDP_TWO_PORT = 8'h02;
   // bits of the descriptor that software can change (dt and port count are fixed)
   localparam logic [31:0] RHD_DESC_A_WMASK = 32'hFFFF_FB00;

   // ==========================================
   // timing
   localparam int RHD_PGW_UNIT_MS = 2;

   // ==========================================
   // types
   typedef enum logic [1:0] {RHD_OC_NONE, RHD_OC_GLOBAL, RHD_OC_PER_PORT} rhd_oc_mode_e;
   typedef enum logic [1:0] {RHD_PWR_ALWAYS, RHD_PWR_GANGED, RHD_PWR_PER_PORT} rhd_pwr_mode_e;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } rhd_req_s;

   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } rhd_rsp_s;
endpackage

// ### rhd_ls_commit.sv
// low-speed transaction commit check against the frame-remaining count
`timescale 1ns/1ps
`default_nettype none
module rhd_ls_commit (
   input wire logic clk,
   input wire logic rst,
   input wire logic ls_req,
   input wire logic [rhd_pkg::RHD_FR_W-1:0] frame_remaining_count,
   input wire logic [rhd_pkg::RHD_LST_MSB:0] low_speed_threshold,
   output logic ls_start,
   output logic ls_refused
);
   import rhd_pkg::*;

   typedef struct packed {
      logic start;
      logic refused;
   } rhd_lsc_s;

   rhd_lsc_s state_reg;
   rhd_lsc_s state_next;
   logic fits;

   // ==========================================
   // commit decision
   always_comb begin
      fits = frame_remaining_count >= {2'b00, low_speed_threshold};
      state_next.start = ls_req && fits;
      state_next.refused = ls_req && !fits;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign ls_start = state_reg.start;
   assign ls_refused = state_reg.refused;
endmodule
`default_nettype wire

// ### rhd_regs.sv
// low-speed threshold and first root hub descriptor registers
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - a low-speed transaction starts only when the frame-remaining count is at least the threshold.
// - the threshold decides whether an 8-byte low-speed packet still fits, and the controller never changes it.
// - no-overcurrent-protection set means no protection, otherwise the mode bit picks the reporting.
// - overcurrent mode zero reports collectively, one reports per port, only while protection exists.
// - at reset the overcurrent mode bit equals the power switching mode bit.
// - the compound device flag is read-only and always reads zero.
// - the port count is read-only and resets to one or two per the port configuration.
// - no-power-switching zero means switched ports, one means always powered.
// - power switch mode, valid with switching, zero gangs all ports, one powers each port alone.
module rhd_regs #(
   parameter int NUM_PORTS = 2
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire rhd_pkg::rhd_req_s REG_REQ,
   output rhd_pkg::rhd_rsp_s REG_RSP,
   input wire logic LS_REQ,
   input wire logic [rhd_pkg::RHD_FR_W-1:0] FRAME_REMAINING_COUNT,
   output logic LS_START,
   output logic LS_REFUSED,
   output rhd_pkg::rhd_oc_mode_e OC_MODE,
   output rhd_pkg::rhd_pwr_mode_e PWR_MODE,
   output logic [7:0] POWER_GOOD_WAIT,
   output logic [7:0] DOWNSTREAM_PORT_COUNT
);
   import rhd_pkg::*;

   // ==========================================
   // parameter checks
   // the port count reset only knows one- and two-port roots
   if (NUM_PORTS != 1 && NUM_PORTS != 2) begin
      $error("NUM_PORTS must be 1 or 2");
   end
   // the commit check pads the threshold by two bits up to the count's width
   if (RHD_LST_MSB + 3 != RHD_FR_W) begin
      $error("threshold and frame-remaining widths disagree");
   end

   // ==========================================
   // descriptor field view and reset values
   typedef struct packed {
      logic [7:0] power_good_wait;
      logic [10:0] reserved_hi;
      logic no_overcurrent_protection;
      logic overcurrent_report_mode;
      logic compound_device_flag;
      logic no_power_switching;
      logic power_switch_mode;
      logic [7:0] downstream_port_count;
   } rhd_desc_a_s;

   localparam logic [7:0] NDP_RST = (NUM_PORTS == 2) ? RHD_NDP_TWO_PORT : RHD_NDP_ONE_PORT;
   // overcurrent mode leaves reset mirroring the power switching mode
   localparam rhd_desc_a_s DESC_A_RST = '{
      power_good_wait: RHD_PGW_RST,
      reserved_hi: 11'h000,
      no_overcurrent_protection: RHD_NO_OVERCURRENT_PROTECTION_RST,
      overcurrent_report_mode: RHD_PSM_RST,
      compound_device_flag: 1'b0,
      no_power_switching: RHD_NPS_RST,
      power_switch_mode: RHD_PSM_RST,
      downstream_port_count: NDP_RST
   };

   // ==========================================
   // state
   typedef enum logic [1:0] {RHD_SEL_NONE, RHD_SEL_THRESH, RHD_SEL_DESC_A} rhd_sel_e;

   typedef struct packed {
      logic [31:0] ls_thresh;
      logic [31:0] desc_a;
      rhd_oc_mode_e oc_mode;
      rhd_pwr_mode_e pwr_mode;
      rhd_rsp_s rsp;
   } rhd_state_s;

   rhd_state_s state_reg;
   rhd_state_s state_next;
   rhd_desc_a_s desc_view;
   rhd_sel_e wr_sel;
   rhd_sel_e rd_sel;
   wire logic [31:0] desc_wr_word;

   // ==========================================
   // mode decoding
   function automatic rhd_oc_mode_e oc_decode(input logic [31:0] d);
      if (d[RHD_NO_OVERCURRENT_PROTECTION_BIT]) begin
         oc_decode = RHD_OC_NONE;
      end else if (d[RHD_OVERCURRENT_REPORT_MODE_BIT]) begin
         oc_decode = RHD_OC_PER_PORT;
      end else begin
         oc_decode = RHD_OC_GLOBAL;
      end
   endfunction

   function automatic rhd_pwr_mode_e pwr_decode(input logic [31:0] d);
      if (d[RHD_NPS_BIT]) begin
         pwr_decode = RHD_PWR_ALWAYS;
      end else if (d[RHD_PSM_BIT]) begin
         pwr_decode = RHD_PWR_PER_PORT;
      end else begin
         pwr_decode = RHD_PWR_GANGED;
      end
   endfunction

   // ==========================================
   // register selection
   // which register an offset names; unmapped offsets select nothing
   function automatic rhd_sel_e addr_decode(input logic [7:0] a);
      case (a)
         RHD_OFS_LS_THRESH: begin
            addr_decode = RHD_SEL_THRESH;
         end
         RHD_OFS_DESC_A: begin
            addr_decode = RHD_SEL_DESC_A;
         end
         default: begin
            addr_decode = RHD_SEL_NONE;
         end
      endcase
   endfunction

   // read data of the selected register; unmapped offsets read zero
   function automatic logic [31:0] read_word(input rhd_sel_e sel, input rhd_state_s st);
      case (sel)
         RHD_SEL_THRESH: begin
            read_word = st.ls_thresh;
         end
         RHD_SEL_DESC_A: begin
            read_word = st.desc_a;
         end
         default: begin
            read_word = 32'h0000_0000;
         end
      endcase
   endfunction

   assign wr_sel = REG_REQ.wr ? addr_decode(REG_REQ.addr) : RHD_SEL_NONE;
   assign rd_sel = REG_REQ.rd ? addr_decode(REG_REQ.addr) : RHD_SEL_NONE;

   // ==========================================
   // reset state
   // modes leave reset already decoded, so the outputs are valid at once
   localparam rhd_state_s STATE_RST = '{
      ls_thresh: RHD_LS_THRESH_RST,
      desc_a: DESC_A_RST,
      oc_mode: oc_decode(DESC_A_RST),
      pwr_mode: pwr_decode(DESC_A_RST),
      rsp: '0
   };

   // ==========================================
   // descriptor write merge, bit by bit
   for (genvar i = 0; i < 32; i++) begin : g_desc_bit
      if (RHD_DESC_A_WMASK[i]) begin : g_rw
         assign desc_wr_word[i] = REG_REQ.wdata[i];
      end else begin : g_ro
         // read-only bit keeps its stored value whatever software writes
         assign desc_wr_word[i] = state_reg.desc_a[i];
      end
   end

   // ==========================================
   // register access
   always_comb begin
      state_next = state_reg;
      // write side; the controller itself never touches the threshold
      case (wr_sel)
         RHD_SEL_THRESH: begin
            state_next.ls_thresh = REG_REQ.wdata;
         end
         RHD_SEL_DESC_A: begin
            state_next.desc_a = desc_wr_word;
         end
         default: begin
            state_next.desc_a = state_reg.desc_a;
         end
      endcase
      // read side sees the old value when a write hits the same cycle
      state_next.rsp.valid = REG_REQ.rd;
      state_next.rsp.data = read_word(rd_sel, state_reg);
      // mode outputs follow the stored bits, new write included
      state_next.oc_mode = oc_decode(state_next.desc_a);
      state_next.pwr_mode = pwr_decode(state_next.desc_a);
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         state_reg <= STATE_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================
   // low-speed commit check
   rhd_ls_commit u_ls_commit (
      .clk(CORE_CLK),
      .rst(RST),
      .ls_req(LS_REQ),
      .frame_remaining_count(FRAME_REMAINING_COUNT),
      .low_speed_threshold(state_reg.ls_thresh[RHD_LST_MSB:0]),
      .ls_start(LS_START),
      .ls_refused(LS_REFUSED)
   );

   // ==========================================
   // outputs, all straight from the state flip-flops
   assign desc_view = state_reg.desc_a;

   assign REG_RSP = state_reg.rsp;
   assign OC_MODE = state_reg.oc_mode;
   assign PWR_MODE = state_reg.pwr_mode;
   assign POWER_GOOD_WAIT = desc_view.power_good_wait;
   assign DOWNSTREAM_PORT_COUNT = desc_view.downstream_port_count;
endmodule
`default_nettype wire

// ### rhd_regs_asserts.sv
// assertion checker for the threshold and descriptor registers
`timescale 1ns/1ps
`default_nettype none
module rhd_regs_asserts #(
   parameter int NUM_PORTS = 2
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire rhd_pkg::rhd_req_s REG_REQ,
   input wire rhd_pkg::rhd_rsp_s REG_RSP,
   input wire logic LS_REQ,
   input wire logic [rhd_pkg::RHD_FR_W-1:0] FRAME_REMAINING_COUNT,
   input wire logic LS_START,
   input wire logic LS_REFUSED,
   input wire rhd_pkg::rhd_oc_mode_e OC_MODE,
   input wire rhd_pkg::rhd_pwr_mode_e PWR_MODE,
   input wire logic [7:0] POWER_GOOD_WAIT,
   input wire logic [7:0] DOWNSTREAM_PORT_COUNT
);
   import rhd_pkg::*;
   localparam logic [7:0] NDP = (NUM_PORTS == 1) ? RHD_NDP_ONE_PORT : RHD_NDP_TWO_PORT;
   // ==========================================
   // shadow of the threshold, follows software writes only
   logic [31:0] thr_reg;
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         thr_reg <= RHD_LS_THRESH_RST;
      end else if (REG_REQ.wr && REG_REQ.addr == RHD_OFS_LS_THRESH) begin
         thr_reg <= REG_REQ.wdata;
      end
   end
   // ==========================================
   // properties
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   sequence s_wr_desc;
      REG_REQ.wr && REG_REQ.addr == RHD_OFS_DESC_A;
   endsequence
   sequence s_rd(logic [7:0] a);
      REG_REQ.rd && REG_REQ.addr == a;
   endsequence
   property p_ls_go;
      LS_REQ && FRAME_REMAINING_COUNT >= thr_reg[RHD_LST_MSB:0] |=> LS_START && !LS_REFUSED;
   endproperty
   property p_ls_no;
      LS_REQ && FRAME_REMAINING_COUNT < thr_reg[RHD_LST_MSB:0] |=> LS_REFUSED && !LS_START;
   endproperty
   property p_ls_idle;
      !LS_REQ |=> !(LS_START || LS_REFUSED);
   endproperty
   property p_rd_thr;
      s_rd(RHD_OFS_LS_THRESH) |=> REG_RSP.valid && REG_RSP.data == $past(thr_reg);
   endproperty
   property p_rd_desc;
      s_rd(RHD_OFS_DESC_A) |=> REG_RSP.valid && !REG_RSP.data[10] && REG_RSP.data[7:0] == NDP;
   endproperty
   property p_oc;
      s_wr_desc |=> OC_MODE == ($past(REG_REQ.wdata[12]) ? RHD_OC_NONE :
         $past(REG_REQ.wdata[11]) ? RHD_OC_PER_PORT : RHD_OC_GLOBAL);
   endproperty
   property p_pwr;
      s_wr_desc |=> PWR_MODE == ($past(REG_REQ.wdata[9]) ? RHD_PWR_ALWAYS :
         $past(REG_REQ.wdata[8]) ? RHD_PWR_PER_PORT : RHD_PWR_GANGED);
   endproperty
   property p_pgw;
      s_wr_desc ##1 1'b1 |-> POWER_GOOD_WAIT == $past(REG_REQ.wdata[31:24]) && DOWNSTREAM_PORT_COUNT == NDP;
   endproperty
   a_ls_go: assert property (p_ls_go) else $error("start missing");
   a_ls_no: assert property (p_ls_no) else $error("refusal missing");
   a_ls_idle: assert property (p_ls_idle) else $error("answer without request");
   a_rd_thr: assert property (p_rd_thr) else $error("threshold readback wrong");
   a_rd_desc: assert property (p_rd_desc) else $error("fixed descriptor bits wrong");
   a_oc: assert property (p_oc) else $error("overcurrent mode wrong");
   a_pwr: assert property (p_pwr) else $error("power mode wrong");
   a_pgw: assert property (p_pgw) else $error("wait byte or port count wrong");
endmodule
`default_nettype wire

// ### tb.sv
// testbench for the threshold and descriptor registers
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rhd_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic ls_req = 1'b0;
   logic [13:0] fr = 14'h0000;
   rhd_req_s req = '0;
   rhd_rsp_s rsp;
   rhd_oc_mode_e oc;
   rhd_pwr_mode_e pwr;
   logic ls_start, ls_ref;
   logic [7:0] pgw, ndp;
   int n_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   rhd_regs #(.NUM_PORTS(2)) dut_u (.CORE_CLK(core_clk), .RST(rst), .REG_REQ(req), .REG_RSP(rsp),
      .LS_REQ(ls_req), .FRAME_REMAINING_COUNT(fr), .LS_START(ls_start), .LS_REFUSED(ls_ref),
      .OC_MODE(oc), .PWR_MODE(pwr), .POWER_GOOD_WAIT(pgw), .DOWNSTREAM_PORT_COUNT(ndp));
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   // ==========================================
   // tasks
   task automatic report_and_stop();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      req = '{1'b1, 1'b0, a, 32'h0000_0000};
      @(posedge core_clk) #1;
      chk("rdata", exp, rsp.valid ? rsp.data : 32'hDEAD_BEEF);
      req = '0;
      @(posedge core_clk) #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      req = '{1'b0, 1'b1, a, d};
      @(posedge core_clk) #1;
      req = '0;
   endtask
   task automatic mode(input logic [31:0] d, input logic [1:0] eo, input logic [1:0] ep);
      wr(RHD_OFS_DESC_A, d);
      chk("oc", eo, oc);
      chk("pwr", ep, pwr);
      chk("pgw", d[31:24], pgw);
      @(posedge core_clk) #1;
   endtask
   task automatic ls(input logic [13:0] f, input logic [1:0] exp);
      ls_req = 1'b1;
      fr = f;
      @(posedge core_clk) #1;
      ls_req = 1'b0;
      chk("ls", exp, {ls_start, ls_ref});
      @(posedge core_clk) #1;
   endtask
   // ==========================================
   // run, with a cycle ceiling far above the roughly forty cycles needed
   always @(posedge core_clk) begin
      cyc++;
      if (cyc > 2000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (10) @(posedge core_clk);
      #1 rst = 1'b0;
      rd(RHD_OFS_LS_THRESH, 32'h0000_0628);
      rd(RHD_OFS_DESC_A, 32'hFF00_0902);
      chk("oc", RHD_OC_PER_PORT, oc);
      ls(14'h0628, 2'b10);
      ls(14'h0627, 2'b01);
      rd(8'h50, 32'h0000_0000);
      wr(RHD_OFS_LS_THRESH, 32'h0000_0FFF);
      @(posedge core_clk) #1;
      ls(14'h0FFE, 2'b01);
      ls(14'h3FFF, 2'b10);
      rd(RHD_OFS_LS_THRESH, 32'h0000_0FFF);
      mode(32'h0000_1000, RHD_OC_NONE, RHD_PWR_GANGED);
      mode(32'h2A00_0FFF, RHD_OC_PER_PORT, RHD_PWR_ALWAYS);
      rd(RHD_OFS_DESC_A, 32'h2A00_0B02);
      mode(32'h0000_0100, RHD_OC_GLOBAL, RHD_PWR_PER_PORT);
      chk("ndp", RHD_NDP_TWO_PORT, ndp);
      // a second reset in mid-run must bring back every reset value
      rst = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 rst = 1'b0;
      chk("pgw", 32'h0000_00FF, pgw);
      chk("oc", RHD_OC_PER_PORT, oc);
      chk("pwr", RHD_PWR_PER_PORT, pwr);
      rd(RHD_OFS_DESC_A, 32'hFF00_0902);
      rd(RHD_OFS_LS_THRESH, 32'h0000_0628);
      report_and_stop();
   end
endmodule
bind rhd_regs rhd_regs_asserts #(.NUM_PORTS(NUM_PORTS)) chk_u (.CORE_CLK(CORE_CLK), .RST(RST), .REG_REQ(REG_REQ),
   .REG_RSP(REG_RSP), .LS_REQ(LS_REQ), .FRAME_REMAINING_COUNT(FRAME_REMAINING_COUNT), .LS_START(LS_START),
   .LS_REFUSED(LS_REFUSED), .OC_MODE(OC_MODE), .PWR_MODE(PWR_MODE), .POWER_GOOD_WAIT(POWER_GOOD_WAIT),
   .DOWNSTREAM_PORT_COUNT(DOWNSTREAM_PORT_COUNT));
`default_nettype wire
